/* File: src/iors_bus_if.sv */
// Request/answer link between processor core and I/O register space.
// Both ends share one clock; the testbench supplies it to each module.
`timescale 1ns/1ps
`default_nettype none
interface iors_bus_if;
	logic req_valid;
	iors_pkg::iors_op_t req_op;
	logic [7:0] req_addr;
	logic [2:0] req_bit;
	logic [7:0] req_wdata;
	logic rsp_valid;
	logic [7:0] rsp_rdata;
	logic rsp_bit;
	logic rsp_err;

	modport dev (
		input req_valid, req_op, req_addr, req_bit, req_wdata,
		output rsp_valid, rsp_rdata, rsp_bit, rsp_err
	);
	modport core (
		output req_valid, req_op, req_addr, req_bit, req_wdata,
		input rsp_valid, rsp_rdata, rsp_bit, rsp_err
	);
endinterface
`default_nettype wire

/* File: src/iors_core.sv */
// Core end: turns user commands into I/O or data-space accesses.
// Assumes one outstanding access; device answers on the bus.
`timescale 1ns/1ps
`default_nettype none
module iors_core (
	// Clock, reset, enable
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// User commands
	input wire logic cmd_valid_in,
	input wire iors_pkg::iors_op_t cmd_op_in,
	input wire logic [7:0] cmd_addr_in,
	input wire logic [2:0] cmd_bit_in,
	input wire logic [7:0] cmd_wdata_in,
	input wire logic cmd_via_data_in,
	output logic cmd_ready_out,
	// Results
	output logic done_out,
	output logic [7:0] rdata_out,
	output logic skip_out,
	output logic err_out,
	// Device link
	iors_bus_if.core bus
);
	typedef enum logic {S_IDLE, S_WAIT} iors_core_state_t;

	iors_core_state_t state_q;
	iors_pkg::iors_op_t op_q;
	logic is_io_op;
	logic is_bit_op;
	logic is_write;
	logic [7:0] data_addr;
	logic refuse;
	logic take;
	iors_pkg::iors_op_t bus_op;

	// ==========================================================
	// Command decode
	assign is_bit_op = cmd_op_in inside {iors_pkg::OP_IO_BIT_SET,
		iors_pkg::OP_IO_BIT_CLEAR, iors_pkg::OP_SKIP_IF_BIT_SET,
		iors_pkg::OP_SKIP_IF_BIT_CLEAR};
	assign is_io_op = is_bit_op || cmd_op_in inside
		{iors_pkg::OP_IO_READ, iors_pkg::OP_IO_WRITE};
	assign is_write = cmd_op_in inside {iors_pkg::OP_IO_WRITE,
		iors_pkg::OP_DATA_SPACE_WRITE, iors_pkg::OP_IO_BIT_SET,
		iors_pkg::OP_IO_BIT_CLEAR};
	// Plain I/O access may be sent as the equivalent data-space access
	assign data_addr = is_io_op ?
		8'(cmd_addr_in + iors_pkg::IO_DATA_OFFSET) : cmd_addr_in;
	assign bus_op = (cmd_via_data_in && cmd_op_in == iors_pkg::OP_IO_READ) ?
		iors_pkg::OP_DATA_SPACE_READ :
		(cmd_via_data_in && cmd_op_in == iors_pkg::OP_IO_WRITE) ?
		iors_pkg::OP_DATA_SPACE_WRITE : cmd_op_in;
	// Refused locally, never put on the bus
	assign refuse = (is_io_op && cmd_addr_in > iors_pkg::IO_ADDR_MAX) ||
		(is_bit_op && cmd_addr_in > iors_pkg::IO_BIT_ADDR_MAX) ||
		(is_write && iors_pkg::impl_mask(data_addr) == 8'h00);
	assign take = ce_in && state_q == S_IDLE && cmd_valid_in;

	// ==========================================================
	// Sequencer
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_q <= S_IDLE;
			op_q <= iors_pkg::OP_IO_READ;
			cmd_ready_out <= 1'b0;
			done_out <= 1'b0;
			rdata_out <= iors_pkg::RESET_VALUE;
			skip_out <= 1'b0;
			err_out <= 1'b0;
			bus.req_valid <= 1'b0;
			bus.req_op <= iors_pkg::OP_IO_READ;
			bus.req_addr <= iors_pkg::RESET_VALUE;
			bus.req_bit <= 3'h0;
			bus.req_wdata <= iors_pkg::RESET_VALUE;
		end else if (ce_in) begin
			bus.req_valid <= 1'b0;
			done_out <= 1'b0;
			cmd_ready_out <= 1'b0;
			case (state_q)
				S_IDLE: begin
					cmd_ready_out <= !cmd_valid_in;
					if (take && refuse) begin
						done_out <= 1'b1;
						err_out <= 1'b1;
						skip_out <= 1'b0;
						rdata_out <= iors_pkg::RESET_VALUE;
					end else if (take) begin
						state_q <= S_WAIT;
						op_q <= cmd_op_in;
						bus.req_valid <= 1'b1;
						bus.req_op <= bus_op;
						bus.req_addr <= (bus_op == cmd_op_in) ?
							cmd_addr_in : data_addr;
						bus.req_bit <= cmd_bit_in;
						// Reserved bits always go out as zero
						bus.req_wdata <= cmd_wdata_in &
							iors_pkg::impl_mask(data_addr);
					end
				end
				S_WAIT: begin
					if (bus.rsp_valid) begin
						state_q <= S_IDLE;
						cmd_ready_out <= 1'b1;
						done_out <= 1'b1;
						err_out <= bus.rsp_err;
						rdata_out <= bus.rsp_rdata;
						skip_out <= !bus.rsp_err &&
							((op_q == iors_pkg::OP_SKIP_IF_BIT_SET && bus.rsp_bit) ||
							(op_q == iors_pkg::OP_SKIP_IF_BIT_CLEAR &&
							!bus.rsp_bit));
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: src/iors_device.sv */
// Device end: the I/O register space with its two address windows.
// Assumes the core keeps one request in flight; peripherals set flags.
//
// Behaviour
// - Bit set/clear reach I/O 0x00-0x1F
// - Bit tests return current bit value
// - Flags clear on written one only
// - Bit ops touch only the addressed bit
// - I/O instructions decode exactly 0x00-0x3F
// - Data-space address equals I/O address plus 0x20
// - Extended 0x60-0xFF only by data-space access
// - Software writes reserved bits as zero
// - Software never writes reserved locations
`timescale 1ns/1ps
`default_nettype none
module iors_device #(
	parameter int unsigned FLAG_REGS = iors_pkg::FLAG_REGS
) (
	// Clock, reset, enable
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Flag events from peripherals, one byte per flag register
	input wire logic [FLAG_REGS-1:0][7:0] flag_set_in,
	// Flag register contents
	output logic [FLAG_REGS-1:0][7:0] flag_state_out,
	// Core link
	iors_bus_if.dev bus
);

	// ==========================================================
	// Storage for data-space 0x20-0xFF
	logic [7:0] regs_q [iors_pkg::SPACE_WORDS];

	// ==========================================================
	// Request decode
	logic is_io_op;
	logic is_bit_op;
	logic is_skip_op;
	logic is_set_op;
	logic is_clear_op;
	logic is_full_write;
	logic addr_err;
	logic [7:0] data_addr;
	logic [7:0] word_idx;
	logic [7:0] impl;
	logic [7:0] w1c;
	logic [7:0] cur;
	logic [7:0] bit_sel;
	logic [7:0] sel;
	logic [7:0] pat;
	logic [7:0] new_val;
	logic wr_en;
	logic [7:0] flag_word [FLAG_REGS];

	assign is_set_op = bus.req_op == iors_pkg::OP_IO_BIT_SET;
	assign is_clear_op = bus.req_op == iors_pkg::OP_IO_BIT_CLEAR;
	assign is_skip_op = bus.req_op inside {iors_pkg::OP_SKIP_IF_BIT_SET,
		iors_pkg::OP_SKIP_IF_BIT_CLEAR};
	assign is_bit_op = is_set_op || is_clear_op || is_skip_op;
	assign is_io_op = is_bit_op || bus.req_op inside
		{iors_pkg::OP_IO_READ, iors_pkg::OP_IO_WRITE};
	assign is_full_write = bus.req_op inside
		{iors_pkg::OP_IO_WRITE, iors_pkg::OP_DATA_SPACE_WRITE};

	// I/O numbers sit 0x20 below their data-space addresses
	assign data_addr = is_io_op ?
		8'(bus.req_addr + iors_pkg::IO_DATA_OFFSET) :
		bus.req_addr;

	// An I/O number above 0x3F would alias the extended space; refuse it
	assign addr_err =
		(is_io_op && bus.req_addr > iors_pkg::IO_ADDR_MAX) ||
		(is_bit_op && bus.req_addr > iors_pkg::IO_BIT_ADDR_MAX) ||
		(!is_io_op && bus.req_addr < iors_pkg::IO_DATA_OFFSET);

	assign word_idx = 8'(data_addr - iors_pkg::IO_DATA_OFFSET);
	assign impl = iors_pkg::impl_mask(data_addr);
	assign w1c = iors_pkg::w1c_mask(data_addr);
	// Reserved bits and reserved locations read as zero
	assign cur = addr_err ? 8'h00 : (regs_q[word_idx] & impl);

	// ==========================================================
	// Write value
	// Bit ops select one bit; a full write selects all. Inside the
	// selection plain bits take the pattern and flag bits clear where
	// the pattern holds a one. Outside it nothing changes, so a bit
	// op never wipes a neighbouring flag.
	assign bit_sel = 8'(8'h01 << bus.req_bit);
	assign sel = is_full_write ? 8'hFF : bit_sel;
	assign pat = is_full_write ? bus.req_wdata :
		(is_set_op ? bit_sel : 8'h00);
	assign new_val = ((cur & ~sel) |
		(pat & sel & ~w1c) |
		(cur & sel & w1c & ~pat)) & impl;
	// Same write path whichever window was used
	assign wr_en = bus.req_valid && !addr_err && impl != 8'h00 &&
		(is_full_write || is_set_op || is_clear_op);

	// ==========================================================
	// Hardware flag sets, routed by location
	function automatic logic [7:0] hw_set(input logic [7:0] da,
		input logic [FLAG_REGS-1:0][7:0] ev);
		logic [7:0] acc;
		acc = 8'h00;
		for (int k = 0; k < FLAG_REGS; k++) begin
			if (iors_pkg::FLAG_ADDR[k] == da) begin
				acc = acc | ev[k];
			end
		end
		hw_set = acc & iors_pkg::w1c_mask(da);
	endfunction

	// ==========================================================
	// Register array
	// A flag raised in the same cycle as its clear stays set.
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < iors_pkg::SPACE_WORDS; i++) begin
				regs_q[i] <= iors_pkg::RESET_VALUE;
			end
		end else if (ce_in) begin
			for (int i = 0; i < iors_pkg::SPACE_WORDS; i++) begin
				regs_q[i] <= ((wr_en && word_idx == 8'(i)) ?
					new_val : regs_q[i]) |
					hw_set(8'(i + iors_pkg::IO_DATA_OFFSET), flag_set_in);
			end
		end
	end

	// ==========================================================
	// Flag state view
	genvar g;
	generate
		for (g = 0; g < FLAG_REGS; g++) begin : g_flag
			assign flag_word[g] = regs_q[8'(iors_pkg::FLAG_ADDR[g] -
				iors_pkg::IO_DATA_OFFSET)];
			assign flag_state_out[g] = flag_word[g];
		end
	endgenerate

	// ==========================================================
	// Answer, one cycle after the request
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			bus.rsp_valid <= 1'b0;
			bus.rsp_rdata <= iors_pkg::RESET_VALUE;
			bus.rsp_bit <= 1'b0;
			bus.rsp_err <= 1'b0;
		end else if (ce_in) begin
			bus.rsp_valid <= bus.req_valid;
			if (bus.req_valid) begin
				bus.rsp_err <= addr_err;
				bus.rsp_rdata <= cur;
				bus.rsp_bit <= cur[bus.req_bit];
			end
		end
	end

endmodule
`default_nettype wire

/* File: src/iors_pkg.sv */
// I/O register space package: opcodes, address map, bit layouts.
// Assumes 8-bit data addresses; the 32 working registers sit below 0x20.
`default_nettype none
package iors_pkg;

	// ==========================================================
	// Access kinds
	typedef enum logic [2:0] {
		OP_IO_READ,
		OP_IO_WRITE,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_SKIP_IF_BIT_SET,
		OP_SKIP_IF_BIT_CLEAR,
		OP_DATA_SPACE_READ,
		OP_DATA_SPACE_WRITE
	} iors_op_t;

	// ==========================================================
	// Address ranges
	localparam logic [7:0] IO_ADDR_MAX = 8'h3F;
	localparam logic [7:0] IO_BIT_ADDR_MAX = 8'h1F;
	localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
	localparam logic [7:0] EXT_IO_FIRST = 8'h60;
	localparam int unsigned SPACE_WORDS = 224;
	localparam logic [7:0] RESET_VALUE = 8'h00;

	// ==========================================================
	// Data-space addresses
	localparam logic [7:0] DA_PORT_B_INPUT = 8'h23;
	localparam logic [7:0] DA_PORT_B_DIR = 8'h24;
	localparam logic [7:0] DA_PORT_B_OUT = 8'h25;
	localparam logic [7:0] DA_PORT_C_INPUT = 8'h26;
	localparam logic [7:0] DA_PORT_C_DIR = 8'h27;
	localparam logic [7:0] DA_PORT_C_OUT = 8'h28;
	localparam logic [7:0] DA_PORT_D_INPUT = 8'h29;
	localparam logic [7:0] DA_PORT_D_DIR = 8'h2A;
	localparam logic [7:0] DA_PORT_D_OUT = 8'h2B;
	localparam logic [7:0] DA_TIMER0_FLAGS = 8'h35;
	localparam logic [7:0] DA_TIMER1_FLAGS = 8'h36;
	localparam logic [7:0] DA_TIMER2_FLAGS = 8'h37;
	localparam logic [7:0] DA_PIN_CHANGE_FLAGS = 8'h3B;
	localparam logic [7:0] DA_EXT_IRQ_FLAGS = 8'h3C;
	localparam logic [7:0] DA_EXT_IRQ_MASK = 8'h3D;
	localparam logic [7:0] DA_GENERAL_SCRATCH_0 = 8'h3E;
	localparam logic [7:0] DA_NV_CONTROL = 8'h3F;
	localparam logic [7:0] DA_NV_DATA = 8'h40;
	localparam logic [7:0] DA_NV_ADDR_LOW = 8'h41;
	localparam logic [7:0] DA_NV_ADDR_HIGH = 8'h42;
	localparam logic [7:0] DA_GENERAL_TIMER_SYNC_CONTROL = 8'h43;
	localparam logic [7:0] DA_TIMER0_CONTROL_A = 8'h44;
	localparam logic [7:0] DA_TIMER0_CONTROL_B = 8'h45;
	localparam logic [7:0] DA_TIMER0_COUNT = 8'h46;
	localparam logic [7:0] DA_TIMER0_COMPARE_A = 8'h47;
	localparam logic [7:0] DA_TIMER0_COMPARE_B = 8'h48;
	localparam logic [7:0] DA_GENERAL_SCRATCH_1 = 8'h4A;
	localparam logic [7:0] DA_GENERAL_SCRATCH_2 = 8'h4B;
	localparam logic [7:0] DA_SERIAL_PERIPHERAL_CONTROL = 8'h4C;
	localparam logic [7:0] DA_SERIAL_PERIPHERAL_STATUS = 8'h4D;
	localparam logic [7:0] DA_SERIAL_PERIPHERAL_DATA = 8'h4E;
	localparam logic [7:0] DA_ANALOG_COMPARATOR_CONTROL = 8'h50;
	localparam logic [7:0] DA_SLEEP_MODE_CONTROL = 8'h53;
	localparam logic [7:0] DA_RESET_CAUSE_STATUS = 8'h54;
	localparam logic [7:0] DA_CORE_CONTROL = 8'h55;
	localparam logic [7:0] DA_SELF_PROGRAM_CONTROL = 8'h57;
	localparam logic [7:0] DA_STACK_POINTER_LOW = 8'h5D;
	localparam logic [7:0] DA_STACK_POINTER_HIGH = 8'h5E;
	localparam logic [7:0] DA_PROCESSOR_STATUS_FLAGS = 8'h5F;
	localparam logic [7:0] DA_WATCHDOG_CONTROL_STATUS = 8'h60;
	localparam logic [7:0] DA_CLOCK_PRESCALE_CONTROL = 8'h61;
	localparam logic [7:0] DA_POWER_REDUCTION_GATES = 8'h64;
	localparam logic [7:0] DA_OSCILLATOR_TRIM = 8'h66;
	localparam logic [7:0] DA_PIN_CHANGE_IRQ_ENABLE = 8'h68;

	// ==========================================================
	// Hardware-set flag registers, in event port order
	localparam int unsigned FLAG_REGS = 7;
	localparam logic [7:0] FLAG_ADDR [FLAG_REGS] = '{
		DA_TIMER0_FLAGS, DA_TIMER1_FLAGS, DA_TIMER2_FLAGS,
		DA_PIN_CHANGE_FLAGS, DA_EXT_IRQ_FLAGS,
		DA_ANALOG_COMPARATOR_CONTROL, DA_WATCHDOG_CONTROL_STATUS};

	// ==========================================================
	// Implemented bits per location; zero means reserved location
	function automatic logic [7:0] impl_mask(input logic [7:0] da);
		case (da)
			DA_PORT_C_INPUT, DA_PORT_C_DIR, DA_PORT_C_OUT: impl_mask = 8'h7F;
			DA_PORT_B_INPUT, DA_PORT_B_DIR, DA_PORT_B_OUT,
			DA_PORT_D_INPUT, DA_PORT_D_DIR, DA_PORT_D_OUT,
			DA_GENERAL_SCRATCH_0, DA_NV_DATA, DA_NV_ADDR_LOW,
			DA_TIMER0_COUNT, DA_TIMER0_COMPARE_A, DA_TIMER0_COMPARE_B,
			DA_GENERAL_SCRATCH_1, DA_GENERAL_SCRATCH_2,
			DA_SERIAL_PERIPHERAL_CONTROL, DA_SERIAL_PERIPHERAL_DATA,
			DA_ANALOG_COMPARATOR_CONTROL, DA_STACK_POINTER_LOW,
			DA_PROCESSOR_STATUS_FLAGS, DA_WATCHDOG_CONTROL_STATUS,
			DA_OSCILLATOR_TRIM: impl_mask = 8'hFF;
			DA_TIMER0_FLAGS, DA_TIMER2_FLAGS, DA_PIN_CHANGE_FLAGS,
			DA_STACK_POINTER_HIGH, DA_PIN_CHANGE_IRQ_ENABLE: impl_mask = 8'h07;
			DA_TIMER1_FLAGS: impl_mask = 8'h27;
			DA_EXT_IRQ_FLAGS, DA_EXT_IRQ_MASK, DA_NV_ADDR_HIGH:
				impl_mask = 8'h03;
			DA_NV_CONTROL: impl_mask = 8'h3F;
			DA_GENERAL_TIMER_SYNC_CONTROL: impl_mask = 8'h83;
			DA_TIMER0_CONTROL_A: impl_mask = 8'hF3;
			DA_TIMER0_CONTROL_B: impl_mask = 8'hCF;
			DA_SERIAL_PERIPHERAL_STATUS: impl_mask = 8'hC1;
			DA_SLEEP_MODE_CONTROL, DA_RESET_CAUSE_STATUS: impl_mask = 8'h0F;
			DA_CORE_CONTROL: impl_mask = 8'h73;
			DA_SELF_PROGRAM_CONTROL: impl_mask = 8'hDF;
			DA_CLOCK_PRESCALE_CONTROL: impl_mask = 8'h8F;
			DA_POWER_REDUCTION_GATES: impl_mask = 8'hEF;
			default: impl_mask = 8'h00;
		endcase
	endfunction

	// Bits cleared by writing a one
	function automatic logic [7:0] w1c_mask(input logic [7:0] da);
		case (da)
			DA_TIMER0_FLAGS, DA_TIMER1_FLAGS, DA_TIMER2_FLAGS,
			DA_PIN_CHANGE_FLAGS, DA_EXT_IRQ_FLAGS: w1c_mask = 8'hFF;
			DA_ANALOG_COMPARATOR_CONTROL: w1c_mask = 8'h10;
			DA_WATCHDOG_CONTROL_STATUS: w1c_mask = 8'h80;
			default: w1c_mask = 8'h00;
		endcase
	endfunction

endpackage
`default_nettype wire

/* File: testbench/io_register_space_decode_tb_top.sv */
// Bench joining core and device ends; commands in, results scored.
// Assumes both ends run on one clock; ce_in drops only between commands.
`timescale 1ns/1ps
`default_nettype none
module io_register_space_decode_tb_top;
	typedef struct packed {
		logic [7:0] rd;
		logic rd_en;
		logic sk;
		logic sk_en;
		logic err;
	} iors_exp_t;
	localparam iors_exp_t WR_OK = 12'h000;
	localparam iors_exp_t REFUSE = 12'h001;
	localparam logic [7:0] RW_IO [6] = '{8'h05, 8'h0A, 8'h1E, 8'h2A, 8'h2E, 8'h3F};
	localparam logic [7:0] BAD_ADDR [8] = '{8'h40, 8'h40, 8'h20, 8'h20, 8'h20,
		8'h3F, 8'h1F, 8'h00};
	logic core_clk_in;
	logic rst_in;
	logic ce_in;
	logic cmd_valid_in;
	iors_pkg::iors_op_t cmd_op_in;
	logic [7:0] cmd_addr_in;
	logic [2:0] cmd_bit_in;
	logic [7:0] cmd_wdata_in;
	logic cmd_via_data_in;
	logic cmd_ready_out;
	logic done_out;
	logic skip_out;
	logic err_out;
	logic [7:0] rdata_out;
	logic [iors_pkg::FLAG_REGS-1:0][7:0] flag_set_in;
	logic [iors_pkg::FLAG_REGS-1:0][7:0] flag_state_out;
	logic [31:0] lfsr_q;
	int err_total;
	int samples_checked;
	iors_exp_t exp_q[$];
	iors_exp_t cur;
	// ==========================================================
	// Two ends, link and checker
	iors_bus_if bus ();
	iors_core i_iors_core (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.ce_in(ce_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
		.cmd_addr_in(cmd_addr_in), .cmd_bit_in(cmd_bit_in),
		.cmd_wdata_in(cmd_wdata_in), .cmd_via_data_in(cmd_via_data_in),
		.cmd_ready_out(cmd_ready_out), .done_out(done_out),
		.rdata_out(rdata_out), .skip_out(skip_out), .err_out(err_out),
		.bus(bus));
	iors_device i_iors_device (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.ce_in(ce_in), .flag_set_in(flag_set_in),
		.flag_state_out(flag_state_out), .bus(bus));
	iors_bus_monitor i_iors_bus_monitor (.core_clk_in(core_clk_in),
		.rst_in(rst_in), .req_valid(bus.req_valid), .req_op(bus.req_op),
		.req_addr(bus.req_addr), .req_bit(bus.req_bit),
		.req_wdata(bus.req_wdata), .rsp_valid(bus.rsp_valid),
		.rsp_rdata(bus.rsp_rdata), .rsp_bit(bus.rsp_bit),
		.rsp_err(bus.rsp_err));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp_byte(input string what, input logic [7:0] e,
		input logic [7:0] s);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic cmp_bit(input string what, input logic e, input logic s);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %b seen %b", what, e, s);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Holds the command until done; waiting commands are not retaken
	task automatic run(input iors_pkg::iors_op_t op, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] d, input logic via,
		input iors_exp_t e);
		int n;
		exp_q.push_back(e);
		@(posedge core_clk_in);
		#1;
		cmp_bit("cmd_ready_out", 1'b1, cmd_ready_out);
		cmd_valid_in = 1'b1;
		cmd_op_in = op;
		cmd_addr_in = a;
		cmd_bit_in = b;
		cmd_wdata_in = d;
		cmd_via_data_in = via;
		n = 0;
		do begin
			@(posedge core_clk_in);
			#1;
			n++;
		end while (done_out !== 1'b1 && n < 12);
		cmd_valid_in = 1'b0;
		if (done_out !== 1'b1) begin
			err_total++;
			$display("Error done_out expected 1 seen %b", done_out);
			conclude();
		end
	endtask
	// ==========================================================
	// Result watcher
	always @(negedge core_clk_in) begin
		if (done_out === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_total++;
				$display("Error done_out expected 0 seen 1");
			end else begin
				cur = exp_q.pop_front();
				cmp_bit("err_out", cur.err, err_out);
				if (cur.rd_en) cmp_byte("rdata_out", cur.rd, rdata_out);
				if (cur.sk_en) cmp_bit("skip_out", cur.sk, skip_out);
			end
		end
	end
	initial begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end
	// ==========================================================
	// Main sequence
	initial begin
		logic [7:0] d;
		int i;
		rst_in = 1'b1;
		ce_in = 1'b1;
		cmd_valid_in = 1'b0;
		cmd_op_in = iors_pkg::OP_IO_READ;
		cmd_addr_in = 8'h00;
		cmd_bit_in = 3'h0;
		cmd_wdata_in = 8'h00;
		cmd_via_data_in = 1'b0;
		flag_set_in = '0;
		lfsr_q = 32'h86933C4E;
		err_total = 0;
		samples_checked = 0;
		repeat (12) @(posedge core_clk_in);
		#1;
		rst_in = 1'b0;
		// Both windows reach one register
		for (i = 0; i < 6; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			d = lfsr_q[7:0];
			run(iors_pkg::OP_IO_WRITE, RW_IO[i], 3'h0, d, lfsr_q[8],
				WR_OK);
			run(iors_pkg::OP_IO_READ, RW_IO[i], 3'h0, 8'h00, lfsr_q[9],
				{d, 4'h8});
			run(iors_pkg::OP_DATA_SPACE_READ, RW_IO[i] + 8'h20, 3'h0,
				8'h00, 1'b0, {d, 4'h8});
		end
		// Every access kind refused outside its range
		for (i = 0; i < 8; i++) begin
			run(iors_pkg::iors_op_t'(i), BAD_ADDR[i], 3'h1, 8'h00, 1'b0,
				REFUSE);
		end
		// Reserved bits dropped, reserved locations never written
		run(iors_pkg::OP_IO_WRITE, 8'h06, 3'h0, 8'hFF, 1'b0, WR_OK);
		run(iors_pkg::OP_IO_READ, 8'h06, 3'h0, 8'h00, 1'b0, 12'h7F8);
		run(iors_pkg::OP_DATA_SPACE_WRITE, 8'h5A, 3'h0, d, 1'b0,
			REFUSE);
		// Extended region by data space only
		run(iors_pkg::OP_DATA_SPACE_WRITE, 8'h66, 3'h0, d, 1'b0,
			WR_OK);
		run(iors_pkg::OP_DATA_SPACE_READ, 8'h66, 3'h0, 8'h00, 1'b0,
			{d, 4'h8});
		// Walk a one-filled byte in by single bits
		run(iors_pkg::OP_IO_WRITE, 8'h05, 3'h0, 8'h00, 1'b0, WR_OK);
		for (i = 0; i < 8; i++) begin
			run(iors_pkg::OP_IO_BIT_SET, 8'h05, i[2:0], 8'h00, 1'b0,
				WR_OK);
			run(iors_pkg::OP_SKIP_IF_BIT_SET, 8'h05, i[2:0], 8'h00, 1'b0,
				12'h006);
			run(iors_pkg::OP_SKIP_IF_BIT_CLEAR, 8'h05, i[2:0] + 3'h1,
				8'h00, 1'b0, {9'h000, i != 7, 2'h2});
		end
		run(iors_pkg::OP_IO_BIT_CLEAR, 8'h05, 3'h3, 8'h00, 1'b0, WR_OK);
		run(iors_pkg::OP_DATA_SPACE_READ, 8'h25, 3'h0, 8'h00, 1'b0,
			12'hF78);
		// Flags: set by hardware, cleared by a written one
		@(posedge core_clk_in);
		#1;
		flag_set_in[0] = 8'h07;
		@(posedge core_clk_in);
		#1;
		flag_set_in[0] = 8'h00;
		cmp_byte("flag_state_out", 8'h07, flag_state_out[0]);
		run(iors_pkg::OP_IO_WRITE, 8'h15, 3'h0, 8'h02, 1'b0, WR_OK);
		run(iors_pkg::OP_IO_READ, 8'h15, 3'h0, 8'h00, 1'b0, 12'h058);
		run(iors_pkg::OP_IO_BIT_CLEAR, 8'h15, 3'h0, 8'h00, 1'b0, WR_OK);
		run(iors_pkg::OP_DATA_SPACE_READ, 8'h35, 3'h0, 8'h00, 1'b0,
			12'h058);
		run(iors_pkg::OP_IO_BIT_SET, 8'h15, 3'h2, 8'h00, 1'b0, WR_OK);
		run(iors_pkg::OP_IO_READ, 8'h15, 3'h0, 8'h00, 1'b0, 12'h018);
		cmp_byte("flag_state_out", 8'h01, flag_state_out[0]);
		// Hardware set wins over a clear in the same cycle
		flag_set_in[2] = 8'h01;
		run(iors_pkg::OP_IO_WRITE, 8'h17, 3'h0, 8'h01, 1'b0, WR_OK);
		flag_set_in[2] = 8'h00;
		run(iors_pkg::OP_IO_READ, 8'h17, 3'h0, 8'h00, 1'b0, 12'h018);
		// Clock enable low freezes flag sets; link is idle here
		@(posedge core_clk_in);
		#1;
		ce_in = 1'b0;
		flag_set_in[1] = 8'h21;
		repeat (2) @(posedge core_clk_in);
		#1;
		cmp_byte("flag_state_out", 8'h00, flag_state_out[1]);
		ce_in = 1'b1;
		@(posedge core_clk_in);
		#1;
		flag_set_in[1] = 8'h00;
		cmp_byte("flag_state_out", 8'h21, flag_state_out[1]);
		repeat (2) @(posedge core_clk_in);
		if (exp_q.size() != 0) begin
			err_total++;
			$display("Error results expected 0 pending seen %0d", exp_q.size());
		end
		conclude();
	end
endmodule
`default_nettype wire

/* File: testbench/iors_bus_monitor.sv */
// Checker for the request/answer link between core and device ends.
// Assumes ce_in is lowered only while the link is idle.
`timescale 1ns/1ps
`default_nettype none
module iors_bus_monitor (
	// Clock, reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Link signals
	input wire logic req_valid,
	input wire iors_pkg::iors_op_t req_op,
	input wire logic [7:0] req_addr,
	input wire logic [2:0] req_bit,
	input wire logic [7:0] req_wdata,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_rdata,
	input wire logic rsp_bit,
	input wire logic rsp_err
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// ==========================================================
	// Request classes
	wire io_op = req_valid && req_op inside {iors_pkg::OP_IO_READ,
		iors_pkg::OP_IO_WRITE};
	wire test_op = req_valid && req_op inside {iors_pkg::OP_SKIP_IF_BIT_SET,
		iors_pkg::OP_SKIP_IF_BIT_CLEAR};
	wire bit_op = test_op || (req_valid && req_op inside
		{iors_pkg::OP_IO_BIT_SET, iors_pkg::OP_IO_BIT_CLEAR});
	wire data_op = req_valid && req_op inside {iors_pkg::OP_DATA_SPACE_READ,
		iors_pkg::OP_DATA_SPACE_WRITE};
	wire io_high = req_addr > iors_pkg::IO_ADDR_MAX;
	wire bit_high = req_addr > iors_pkg::IO_BIT_ADDR_MAX;
	// ==========================================================
	// Assertions
	a_answer_next_edge: assert property (req_valid |=> rsp_valid)
		else $error("answer missing one edge after request");
	a_no_lone_answer: assert property (rsp_valid |-> $past(req_valid))
		else $error("answer without request");
	a_io_range_refused: assert property (io_op && io_high |=> rsp_err)
		else $error("io access above 0x3F not refused");
	a_io_range_taken: assert property (io_op && !io_high |=> !rsp_err)
		else $error("io access within 0x3F refused");
	a_bit_range_refused: assert property (
		bit_op && bit_high |=> rsp_err)
		else $error("bit access above 0x1F not refused");
	a_bit_range_taken: assert property (
		bit_op && !bit_high |=> !rsp_err)
		else $error("bit access within 0x1F refused");
	a_data_window: assert property (data_op |=>
		rsp_err == ($past(req_addr) < iors_pkg::IO_DATA_OFFSET))
		else $error("data window decode wrong");
	a_refused_reads_zero: assert property (rsp_valid && rsp_err |->
		rsp_rdata == 8'h00)
		else $error("refused access returned data");
	a_bit_test_value: assert property (
		test_op && !bit_high ##1 rsp_valid |->
		rsp_bit == rsp_rdata[$past(req_bit)])
		else $error("tested bit differs from register bit");
	// ==========================================================
	// Coverage
	c_bit_set: cover property (bit_op && req_op == iors_pkg::OP_IO_BIT_SET);
	c_bit_test: cover property (test_op ##1 rsp_bit);
	c_data_refused: cover property (data_op ##1 rsp_err);
	c_io_write: cover property (io_op && req_op == iors_pkg::OP_IO_WRITE);
endmodule
`default_nettype wire
